// [design/dacc_top.sv]
// dual 12-bit converter digital control with axi4-lite register access
// Operation
// - power enable bit per channel drives that channel's analog power pin.
// - each channel has its own output buffer off control bit.
// - single 8-bit right write shifts bits 7:0 left into holding value.
// - single 12-bit right write takes bits 11:0 unchanged.
// - single 12-bit left write takes bits 15:4.
// - dual 8-bit write feeds 7:0 to channel one, 15:8 to two.
// - dual 12-bit left write takes 15:4 and 31:20.
// - dual 12-bit right write takes 11:0 and 27:16.
// - dma enabled channel pulses a request on every hardware trigger.
// - trigger select picks timers, external line, or software trigger.
// - rising edge of selected hardware source updates output four cycles later.
// - software trigger bit loads output next cycle and clears itself.
// - output register is read only, fed only from holding value plus wave generator term.
// - with trigger disabled output follows holding value one cycle later.
// - wave code 10 selects triangle, amplitude field sets its peak.
// - triangle starts at zero, steps per trigger, added without carry.
// - triangle counts up to peak, down to zero, repeats.
// - wave code 00 resets wave generator state.
// - amplitude field is ignored while channel power is on.
// - wave code 01 adds masked noise shift register value.
// - noise register preloads aaa, advances per trigger, escapes zero.
// - with triggers disabled, dual write moves both holding values out one cycle later.
`timescale 1ns/1ps
`default_nettype none
`include "dacc_consts.svh"
module dacc_top (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // write address channel
  input  wire logic [31:0]  s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  // write data channel
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  // write response channel
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  // read address channel
  input  wire logic [31:0]  s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  // read data channel
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  // trigger sources
  input  wire logic [5:0]   timer_trigger_output,
  input  wire logic         external_event_line,
  // analog and dma side
  output logic [1:0]        channel_power_enable,
  output logic [1:0]        output_buffer_off,
  output logic [1:0]        channel_dma_request,
  output dacc_pkg::dacc_val_t channel_output_value_1,
  output dacc_pkg::dacc_val_t channel_output_value_2
);
  import dacc_pkg::*;

  typedef struct packed {
    logic                   awready;
    logic [`DACC_ADDR_W-1:0] awaddr;
    logic                   wready;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    dacc_chctl_s [1:0]      ctl;
    logic [1:0]             sw_bit;
    dacc_val_t [1:0]        hold;
    logic [1:0]             trig_prev;
    logic [1:0]             dma;
  } dacc_st_s;

  dacc_st_s        st_q;
  dacc_st_s        st_d;
  logic [31:0]     wmask;
  logic [7:0]      trig_src;
  logic [1:0]      sig_w;
  logic [1:0]      hw_edge_w;
  logic [1:0]      sw_fire_w;
  dacc_val_t [1:0] out_w;

  dacc_chan_if cif [2] ();

  // strobe lanes expanded to a bit mask
  genvar b;
  for (b = 0; b < 4; b++) begin : g_lane
    assign wmask[8*b +: 8] = {8{st_q.wstrb[b]}};
  end

  // source table, last code is software
  assign trig_src = {1'b0, external_event_line, timer_trigger_output};

  genvar g;
  for (g = 0; g < 2; g++) begin : g_ch
    assign sig_w[g] = trig_src[st_q.ctl[g].trigger_source_select];
    // rising edge of selected hardware source
    assign hw_edge_w[g] = st_q.ctl[g].channel_trigger_enable
                        && (st_q.ctl[g].trigger_source_select != `DACC_TSEL_SW)
                        && sig_w[g] && !st_q.trig_prev[g];
    assign sw_fire_w[g] = st_q.ctl[g].channel_trigger_enable
                        && (st_q.ctl[g].trigger_source_select == `DACC_TSEL_SW)
                        && st_q.sw_bit[g];
    assign cif[g].ctl     = st_q.ctl[g];
    assign cif[g].hold    = st_q.hold[g];
    assign cif[g].hw_edge = hw_edge_w[g];
    assign cif[g].sw_fire = sw_fire_w[g];
    assign out_w[g]       = cif[g].out_val;

    dacc_chan u_chan (
      .aclk    (aclk),
      .aresetn (aresetn),
      .cif     (cif[g])
    );
  end

  always_comb begin
    logic [31:0] wd;
    logic [31:0] cw;
    logic [31:0] rd;
    logic [1:0]  rsp;
    wd   = `DACC_ZERO32;
    cw   = `DACC_ZERO32;
    rd   = `DACC_ZERO32;
    rsp  = `DACC_RESP_OKAY;
    st_d = st_q;

    st_d.trig_prev = sig_w;
    // dma request on hardware triggers only
    st_d.dma[0] = hw_edge_w[0] && st_q.ctl[0].channel_dma_request_enable;
    st_d.dma[1] = hw_edge_w[1] && st_q.ctl[1].channel_dma_request_enable;
    st_d.sw_bit = st_q.sw_bit & ~sw_fire_w;

    // address and data are taken independently
    if (s_axi_awvalid && st_q.awready) begin
      st_d.awready = 1'b0;
      st_d.awaddr  = s_axi_awaddr[`DACC_ADDR_W-1:0];
    end
    if (s_axi_wvalid && st_q.wready) begin
      st_d.wready = 1'b0;
      st_d.wdata  = s_axi_wdata;
      st_d.wstrb  = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid  = 1'b0;
      st_d.awready = 1'b1;
      st_d.wready  = 1'b1;
    end

    // both halves held: perform the write, one per response
    if (!st_q.awready && !st_q.wready && !st_q.bvalid) begin
      wd          = st_q.wdata & wmask;
      cw          = (32'(st_q.ctl) & ~wmask) | wd;
      st_d.bvalid = 1'b1;
      st_d.bresp  = `DACC_RESP_OKAY;
      case (st_q.awaddr)
        `DACC_A_CTRL: begin
          st_d.ctl         = cw;
          st_d.ctl[0].rsvd = '0;
          st_d.ctl[1].rsvd = '0;
        end
        `DACC_A_SWTRG: begin
          // set wins over the same-cycle clear
          st_d.sw_bit = st_d.sw_bit | wd[1:0];
        end
        `DACC_A_R12_1: begin
          st_d.hold[0] = wd[11:0];
        end
        `DACC_A_L12_1: begin
          st_d.hold[0] = wd[15:4];
        end
        `DACC_A_R8_1: begin
          st_d.hold[0] = {wd[7:0], `DACC_PAD4};
        end
        `DACC_A_R12_2: begin
          st_d.hold[1] = wd[11:0];
        end
        `DACC_A_L12_2: begin
          st_d.hold[1] = wd[15:4];
        end
        `DACC_A_R8_2: begin
          // channel two eight bits shifted up
          st_d.hold[1] = {wd[7:0], `DACC_PAD4};
        end
        `DACC_A_DR12: begin
          st_d.hold[0] = wd[11:0];
          st_d.hold[1] = wd[27:16];
        end
        `DACC_A_DL12: begin
          st_d.hold[0] = wd[15:4];
          st_d.hold[1] = wd[31:20];
        end
        `DACC_A_DR8: begin
          // dual eight bits; both move together
          st_d.hold[0] = {wd[7:0], `DACC_PAD4};
          st_d.hold[1] = {wd[15:8], `DACC_PAD4};
        end
        default: begin
          st_d.bresp = `DACC_RESP_SLVERR;
        end
      endcase
    end

    // read decode of the presented address
    case (s_axi_araddr[`DACC_ADDR_W-1:0])
      `DACC_A_CTRL: begin
        rd = 32'(st_q.ctl);
      end
      `DACC_A_SWTRG: begin
        rd = 32'(st_q.sw_bit);
      end
      `DACC_A_R12_1: begin
        rd = 32'(st_q.hold[0]);
      end
      `DACC_A_L12_1: begin
        rd = 32'({st_q.hold[0], `DACC_PAD4});
      end
      `DACC_A_R8_1: begin
        rd = 32'(st_q.hold[0][11:4]);
      end
      `DACC_A_R12_2: begin
        rd = 32'(st_q.hold[1]);
      end
      `DACC_A_L12_2: begin
        rd = 32'({st_q.hold[1], `DACC_PAD4});
      end
      `DACC_A_R8_2: begin
        rd = 32'(st_q.hold[1][11:4]);
      end
      `DACC_A_DR12: begin
        rd = {`DACC_PAD4, st_q.hold[1], `DACC_PAD4, st_q.hold[0]};
      end
      `DACC_A_DL12: begin
        rd = {st_q.hold[1], `DACC_PAD4, st_q.hold[0], `DACC_PAD4};
      end
      `DACC_A_DR8: begin
        rd = 32'({st_q.hold[1][11:4], st_q.hold[0][11:4]});
      end
      // output words are read back only
      `DACC_A_OUT1: begin
        rd = 32'(out_w[0]);
      end
      `DACC_A_OUT2: begin
        rd = 32'(out_w[1]);
      end
      default: begin
        rsp = `DACC_RESP_SLVERR;
      end
    endcase

    if (s_axi_arvalid && st_q.arready) begin
      st_d.arready = 1'b0;
      st_d.rvalid  = 1'b1;
      st_d.rdata   = rd;
      st_d.rresp   = rsp;
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid  = 1'b0;
      st_d.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q         <= '0;
      st_q.awready <= 1'b1;
      st_q.wready  <= 1'b1;
      st_q.arready <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // bus answers straight from state
  assign s_axi_awready = st_q.awready;
  assign s_axi_wready  = st_q.wready;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;
  assign s_axi_rvalid  = st_q.rvalid;

  // start-up settling is left to software; power pin follows the bit at once
  assign channel_power_enable[0] = st_q.ctl[0].channel_power_enable;
  assign channel_power_enable[1] = st_q.ctl[1].channel_power_enable;
  assign output_buffer_off[0]    = st_q.ctl[0].output_buffer_off;
  assign output_buffer_off[1]    = st_q.ctl[1].output_buffer_off;
  assign channel_dma_request     = st_q.dma;
  assign channel_output_value_1  = out_w[0];
  assign channel_output_value_2  = out_w[1];
endmodule
`default_nettype wire

// [pkg/dacc_consts.svh]
// register offsets, field codes and timing counts of the dual converter control
`ifndef DACC_CONSTS_SVH
`define DACC_CONSTS_SVH

`define DACC_ADDR_W        8
`define DACC_A_CTRL        8'h00
`define DACC_A_SWTRG       8'h04
`define DACC_A_R12_1       8'h08
`define DACC_A_L12_1       8'h0C
`define DACC_A_R8_1        8'h10
`define DACC_A_R12_2       8'h14
`define DACC_A_L12_2       8'h18
`define DACC_A_R8_2        8'h1C
`define DACC_A_DR12        8'h20
`define DACC_A_DL12        8'h24
`define DACC_A_DR8         8'h28
`define DACC_A_OUT1        8'h2C
`define DACC_A_OUT2        8'h30

`define DACC_TSEL_EXT      3'h6
`define DACC_TSEL_SW       3'h7
`define DACC_WAVE_OFF      2'h0
`define DACC_WAVE_NOISE    2'h1

`define DACC_HW_TRIG_CYC   2'h3
`define DACC_NOISE_SHIFT_REGISTER_SEED     12'hAAA
`define DACC_NOISE_SHIFT_REGISTER_ONE      12'h001
`define DACC_PAD4          4'h0

`define DACC_RESP_OKAY     2'h0
`define DACC_RESP_SLVERR   2'h2
`define DACC_ZERO32        32'h0000_0000

`endif

// [pkg/dacc_pkg.sv]
// shared types of the dual converter control
`default_nettype none
package dacc_pkg;
  typedef logic [11:0] dacc_val_t;

  typedef struct packed {
    logic [2:0] rsvd;
    logic       channel_dma_request_enable;
    logic [3:0] wave_amplitude_mask;
    logic [1:0] wave_generator_select;
    logic [2:0] trigger_source_select;
    logic       channel_trigger_enable;
    logic       output_buffer_off;
    logic       channel_power_enable;
  } dacc_chctl_s;
endpackage
`default_nettype wire

// [pkg/dacc_chan_if.sv]
// link between the register front end and one converter channel
`timescale 1ns/1ps
`default_nettype none
interface dacc_chan_if;
  import dacc_pkg::*;
  dacc_chctl_s ctl;
  dacc_val_t   hold;
  logic        hw_edge;
  logic        sw_fire;
  dacc_val_t   out_val;

  modport ctrl (output ctl, output hold, output hw_edge, output sw_fire, input out_val);
  modport chan (input ctl, input hold, input hw_edge, input sw_fire, output out_val);
endinterface
`default_nettype wire

// [design/dacc_chan.sv]
// one converter channel: output register, trigger delay and wave generators
`timescale 1ns/1ps
`default_nettype none
`include "dacc_consts.svh"
module dacc_chan (
  // clock and reset
  input  wire logic  aclk,
  input  wire logic  aresetn,
  // control side
  dacc_chan_if.chan  cif
);
  import dacc_pkg::*;

  typedef struct packed {
    dacc_val_t  out_val;
    dacc_val_t  tri_val;
    logic       tri_down;
    dacc_val_t  noise_shift_register;
    logic [3:0] amp;
    logic [1:0] cnt;
  } dacc_chst_s;

  dacc_chst_s st_q;
  dacc_chst_s st_d;
  dacc_val_t  amp_mask;

  genvar i;
  for (i = 0; i < 12; i++) begin : g_mask
    assign amp_mask[i] = (st_q.amp >= 4'(i));
  end

  always_comb begin
    dacc_val_t add_val;
    dacc_val_t nxt;
    logic      load;
    add_val = '0;
    nxt     = '0;
    st_d    = st_q;
    if (!cif.ctl.channel_power_enable) begin
      st_d.amp = cif.ctl.wave_amplitude_mask;
    end
    if (cif.hw_edge) begin
      st_d.cnt = `DACC_HW_TRIG_CYC;
    end else if (st_q.cnt != 2'h0) begin
      st_d.cnt = st_q.cnt - 2'h1;
    end
    load = cif.sw_fire || (st_q.cnt == 2'h1);
    if (cif.ctl.wave_generator_select[1]) begin
      add_val = st_q.tri_val;
    end else if (cif.ctl.wave_generator_select == `DACC_WAVE_NOISE) begin
      add_val = st_q.noise_shift_register & amp_mask;
    end
    if (!cif.ctl.channel_trigger_enable) begin
      st_d.out_val = cif.hold;
    end else if (load) begin
      st_d.out_val = cif.hold + add_val;
      if (cif.ctl.wave_generator_select[1]) begin
        // up to peak, down to zero
        if (!st_q.tri_down) begin
          if (st_q.tri_val >= amp_mask) begin
            st_d.tri_down = 1'b1;
            st_d.tri_val  = st_q.tri_val - 12'h001;
          end else begin
            st_d.tri_val = st_q.tri_val + 12'h001;
          end
        end else if (st_q.tri_val == 12'h000) begin
          st_d.tri_down = 1'b0;
          st_d.tri_val  = 12'h001;
        end else begin
          st_d.tri_val = st_q.tri_val - 12'h001;
        end
      end else if (cif.ctl.wave_generator_select == `DACC_WAVE_NOISE) begin
        nxt = {st_q.noise_shift_register[10:0], st_q.noise_shift_register[11] ^ st_q.noise_shift_register[5] ^ st_q.noise_shift_register[3] ^ st_q.noise_shift_register[0]};
        st_d.noise_shift_register = (nxt == 12'h000) ? `DACC_NOISE_SHIFT_REGISTER_ONE : nxt;
      end
    end
    if (cif.ctl.wave_generator_select == `DACC_WAVE_OFF) begin
      st_d.tri_val  = '0;
      st_d.tri_down = 1'b0;
      st_d.noise_shift_register     = `DACC_NOISE_SHIFT_REGISTER_SEED;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= '{out_val: '0, tri_val: '0, tri_down: 1'b0, noise_shift_register: `DACC_NOISE_SHIFT_REGISTER_SEED,
                amp: '0, cnt: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign cif.out_val = st_q.out_val;
endmodule
`default_nettype wire

// [tb/dacc_top_monitor.sv]
// port-level assertions for the dual converter control
`timescale 1ns/1ps
`default_nettype none
module dacc_top_monitor (
  // clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // register bus
  input wire logic [31:0]         s_axi_awaddr,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic [1:0]          s_axi_bresp,
  input wire logic                s_axi_bvalid,
  // trigger lines
  input wire logic [5:0]          timer_trigger_output,
  input wire logic                external_event_line,
  // converter side
  input wire logic [1:0]          channel_power_enable,
  input wire logic [1:0]          output_buffer_off,
  input wire logic [1:0]          channel_dma_request,
  input wire dacc_pkg::dacc_val_t channel_output_value_1,
  input wire dacc_pkg::dacc_val_t channel_output_value_2
);
  import dacc_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_out_wr;
    s_axi_awvalid && s_axi_awready && (s_axi_awaddr[7:0] inside {8'h2C, 8'h30});
  endsequence
  sequence s_err_resp;
    ##[1:8] (s_axi_bvalid && s_axi_bresp == 2'h2);
  endsequence
  property p_out_ro;
    s_out_wr |-> s_err_resp;
  endproperty
  a_out_ro: assert property (p_out_ro) else $error("output write accepted");
  property p_dma1_pulse;
    channel_dma_request[0] |=> !channel_dma_request[0];
  endproperty
  a_dma1_pulse: assert property (p_dma1_pulse) else $error("dma one too long");
  property p_dma2_pulse;
    channel_dma_request[1] |=> !channel_dma_request[1];
  endproperty
  a_dma2_pulse: assert property (p_dma2_pulse) else $error("dma two too long");
  // output holds in the cycle after the dma pulse
  property p_hw1_hold;
    $rose(channel_dma_request[0]) |=> $stable(channel_output_value_1);
  endproperty
  a_hw1_hold: assert property (p_hw1_hold) else $error("output one too early");
  property p_hw2_hold;
    $rose(channel_dma_request[1]) |=> $stable(channel_output_value_2);
  endproperty
  a_hw2_hold: assert property (p_hw2_hold) else $error("output two too early");
  property p_pwr_wr;
    $changed(channel_power_enable) |-> $rose(s_axi_bvalid);
  endproperty
  a_pwr_wr: assert property (p_pwr_wr) else $error("power changed without write");
  property p_boff_wr;
    $changed(output_buffer_off) |-> $rose(s_axi_bvalid);
  endproperty
  a_boff_wr: assert property (p_boff_wr) else $error("buffer changed without write");
  // output one moves only after a write or a hardware trigger line was high four edges before;
  // the dma pulse is no witness since a channel may run triggered with dma off
  property p_out_cause;
    $changed(channel_output_value_1) |-> $past(s_axi_bvalid)
      || $past(|{external_event_line, timer_trigger_output}, 4);
  endproperty
  a_out_cause: assert property (p_out_cause) else $error("output one moved alone");
endmodule
`default_nettype wire

// [tb/dacc_trig_model.sv]
// trigger source model: timer trigger outputs and external event line
`timescale 1ns/1ps
`default_nettype none
module dacc_trig_model (
  // clock
  input  wire logic       aclk,
  // bench command
  input  wire logic       fire,
  input  wire logic [2:0] src,
  // trigger lines
  output logic [5:0]      timer_trigger_output,
  output logic            external_event_line
);
  logic [2:0] sel_q = 3'h0;
  logic [2:0] cnt_q = 3'h0;
  // level held four cycles, one rising edge
  always_ff @(posedge aclk) begin
    if (fire) begin
      sel_q <= src;
      cnt_q <= 3'h4;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end
  // one line per code, code 6 external
  always_comb begin
    timer_trigger_output = 6'h00;
    external_event_line  = 1'b0;
    if (cnt_q != 3'h0 && sel_q == 3'h6) begin
      external_event_line = 1'b1;
    end else if (cnt_q != 3'h0) begin
      timer_trigger_output[sel_q] = 1'b1;
    end
  end
endmodule
`default_nettype wire

// [tb/dual_dac_digital_control_bench.sv]
// self-checking bench of the dual converter control
`timescale 1ns/1ps
`default_nettype none
`include "dacc_consts.svh"
module dual_dac_digital_control_bench;
  import dacc_pkg::*;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] d;
    logic [1:0]  r;
    dacc_val_t   o1;
    dacc_val_t   o2;
  } dacc_row_s;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fire, ev;
  logic        awrdy, wrdy, bv, arrdy, rv;
  logic [31:0] awaddr, wdata, araddr, rd, rdat;
  logic [1:0]  rs, br, rr, pw, bo, dma;
  logic [5:0]  tt;
  logic [2:0]  src;
  logic [15:0] c;
  dacc_val_t   o1, o2;
  int          err_count, checks, n0;
  int          dma_cnt = 0;
  logic [3:0]  tri_seq [8] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h2, 4'h1, 4'h0, 4'h1};
  dacc_row_s   rows [11] = '{
    '{`DACC_A_R12_1, 32'h0000_0ABC, 2'h0, 12'hABC, 12'h000},
    '{`DACC_A_L12_1, 32'h0000_1230, 2'h0, 12'h123, 12'h000},
    '{`DACC_A_R8_1, 32'h0000_00A5, 2'h0, 12'hA50, 12'h000},
    '{`DACC_A_R12_2, 32'h0000_0456, 2'h0, 12'hA50, 12'h456},
    '{`DACC_A_L12_2, 32'h0000_7890, 2'h0, 12'hA50, 12'h789},
    '{`DACC_A_R8_2, 32'h0000_003C, 2'h0, 12'hA50, 12'h3C0},
    '{`DACC_A_DR12, 32'h0321_0654, 2'h0, 12'h654, 12'h321},
    '{`DACC_A_DL12, 32'hABC0_DEF0, 2'h0, 12'hDEF, 12'hABC},
    '{`DACC_A_DR8, 32'h0000_1234, 2'h0, 12'h340, 12'h120},
    '{`DACC_A_OUT1, 32'h0000_0FFF, 2'h2, 12'h340, 12'h120},
    '{8'h3C, 32'h0000_0055, 2'h2, 12'h340, 12'h120}
  };
  dacc_top i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awrdy),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wrdy),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arrdy),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rready),
    .timer_trigger_output(tt), .external_event_line(ev),
    .channel_power_enable(pw), .output_buffer_off(bo), .channel_dma_request(dma),
    .channel_output_value_1(o1), .channel_output_value_2(o2)
  );
  dacc_trig_model i_trig (
    .aclk(aclk), .fire(fire), .src(src), .timer_trigger_output(tt), .external_event_line(ev)
  );
  always @(posedge aclk) begin
    if (dma != 2'h0) dma_cnt <= dma_cnt + 1;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
    #1;
  endtask
  // ready is read settled before the edge that completes the handshake
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha, hw, hb;
    hb = 1'b0;
    @(posedge aclk);
    awaddr <= {24'h00_0000, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!hb) begin
      #1;
      ha = awvalid && awrdy;
      hw = wvalid && wrdy;
      hb = bv;
      r = br;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hr;
    hr = 1'b0;
    @(posedge aclk);
    araddr <= {24'h00_0000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hr) begin
      #1;
      ha = arvalid && arrdy;
      hr = rv;
      d = rdat;
      r = rr;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask
  task automatic hw_fire(input logic [2:0] s);
    @(posedge aclk);
    src <= s;
    fire <= 1'b1;
    @(posedge aclk);
    fire <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    #250000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, fire} = 7'h00;
    {awaddr, wdata, araddr} = 96'h0;
    src = 3'h0;
    err_count = 0;
    checks = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk("outputs", 32'h0, {8'h00, o2, o1});
    axi_rd(`DACC_A_CTRL, rd, rs);
    chk("ctrl", 32'h0, rd | {28'h000_0000, bo, pw});
    $display("test reset done");
    foreach (rows[i]) begin
      axi_wr(rows[i].a, rows[i].d, rs);
      #1;
      chk("bresp", 32'(rows[i].r), 32'(rs));
      chk("outs", {8'h00, rows[i].o2, rows[i].o1}, {8'h00, o2, o1});
    end
    axi_rd(`DACC_A_OUT2, rd, rs);
    chk("out2 read", 32'h0000_0120, rd);
    axi_rd(8'h3C, rd, rs);
    chk("unmapped", 32'h2, 32'(rs));
    $display("test data formats done");
    axi_wr(`DACC_A_R12_1, 32'h0000_0100, rs);
    // amplitude set powered down, trigger on
    axi_wr(`DACC_A_CTRL, 32'h0000_11BC, rs);
    axi_wr(`DACC_A_CTRL, 32'h0000_15BD, rs);
    n0 = dma_cnt;
    for (int i = 0; i < 8; i++) begin
      axi_wr(`DACC_A_SWTRG, 32'h0000_0001, rs);
      #1;
      chk("triangle", 32'h0000_0100 + 32'(tri_seq[i]), 32'(o1));
    end
    axi_rd(`DACC_A_SWTRG, rd, rs);
    chk("software_trigger_bit bit", 32'h0, rd);
    chk("sw dma", 32'(n0), 32'(dma_cnt));
    // power off and waves off first
    axi_wr(`DACC_A_CTRL, 32'h0000_113C, rs);
    axi_wr(`DACC_A_CTRL, 32'h0000_1B7C, rs);
    axi_wr(`DACC_A_SWTRG, 32'h0000_0001, rs);
    #1;
    chk("noise 1", 32'h0000_0BAA, 32'(o1));
    axi_wr(`DACC_A_SWTRG, 32'h0000_0001, rs);
    #1;
    chk("noise 2", 32'h0000_0655, 32'(o1));
    $display("test waves done");
    for (int k = 0; k < 7; k++) begin
      c = 16'h1004 | {10'h000, 3'(k), 3'h0};
      axi_wr(`DACC_A_CTRL, {c, c}, rs);
      axi_wr(`DACC_A_DR12, {16'h0200 + 16'(k), 16'h0100 + 16'(k)}, rs);
      n0 = dma_cnt;
      hw_fire(3'((k + 1) % 7));
      tick(8);
      chk("other source", 32'(n0), 32'(dma_cnt));
      hw_fire(3'(k));
      for (int n = 0; n < 20 && dma !== 2'h3; n++) tick(1);
      chk("dma", 32'h3, 32'(dma));
      tick(2);
      chk("held", (k == 0) ? 32'h0000_0655 : 32'h0000_00FF + 32'(k), 32'(o1));
      tick(1);
      chk("loaded", {8'h00, 12'h200 + 12'(k), 12'h100 + 12'(k)}, {8'h00, o2, o1});
    end
    axi_wr(`DACC_A_CTRL, 32'h1036_1035, rs);
    #1;
    chk("power buffer", 32'h0000_0009, {28'h000_0000, bo, pw});
    $display("test hardware triggers done");
    // mid-run reset clears pins and outputs
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    chk("reset outs", 32'h0, {8'h00, o2, o1});
    chk("reset pins", 32'h0, {26'h000_0000, dma, bo, pw});
    axi_rd(`DACC_A_CTRL, rd, rs);
    chk("reset ctrl", 32'h0, rd);
    $display("test reset again done");
    tally_and_finish();
  end
endmodule
bind dacc_top dacc_top_monitor i_mon (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .timer_trigger_output(timer_trigger_output), .external_event_line(external_event_line),
  .channel_power_enable(channel_power_enable), .output_buffer_off(output_buffer_off),
  .channel_dma_request(channel_dma_request),
  .channel_output_value_1(channel_output_value_1),
  .channel_output_value_2(channel_output_value_2)
);
`default_nettype wire
